// *** rtl/activity_detector.sv ***
// Toggle activity detector with a quiet-time window
`timescale 1ns/1ps

module activity_detector #(
	parameter int unsigned WINDOW_CYC = 5000
) (
	input  wire logic i_clk_sys, // System clock
	input  wire logic i_rst_n,   // Synchronous reset, active low
	input  wire logic i_signal,  // Watched input, synchronous
	output logic      o_active   // High while toggles keep coming
);

	localparam int unsigned CW = $clog2(WINDOW_CYC + 1);
	localparam logic [CW-1:0] LAST = CW'(WINDOW_CYC - 1);

	typedef struct packed {
		logic          prev;
		logic [CW-1:0] count;
		logic          active;
	} det_t;

	det_t state_reg;
	det_t state_next;

	// ------------------------------------------------------------------
	// Edge restarts the window; a level held past it means no activity
	// ------------------------------------------------------------------
	always_comb begin
		state_next      = state_reg;
		state_next.prev = i_signal;
		if (i_signal != state_reg.prev) begin
			state_next.count  = '0;
			state_next.active = 1'b1;
		end else if (state_reg.count == LAST) begin
			state_next.active = 1'b0;
		end else begin
			state_next.count = state_reg.count + 1'b1;
		end
	end

	// State register
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign o_active = state_reg.active;

endmodule : activity_detector

// *** rtl/source_select.sv ***
// Automatic interface, hsync and vsync source selection with overrides
`timescale 1ns/1ps

module source_select (
	input  wire logic i_hs_det,   // Hsync activity
	input  wire logic i_gs_det,   // Green channel sync activity
	input  wire logic i_vs_det,   // Vsync activity
	input  wire logic i_link_det, // Digital link clock activity
	input  wire logic i_if_ovr,   // interface_select_override
	input  wire logic i_if_sel,   // interface_select_value
	input  wire logic i_hs_ovr,   // Hsync override
	input  wire logic i_hs_sel,   // Hsync select
	input  wire logic i_vs_ovr,   // Vsync override
	input  wire logic i_vs_sel,   // Vsync select
	output logic      o_if_act,   // 1 digital, 0 analog
	output logic      o_hs_act,   // 1 green sync, 0 hsync input
	output logic      o_vs_act,   // 1 separator, 0 vsync input
	output logic      o_seek      // Nothing found, seeking
);

	logic analog_det;

	// Analog side counts as present on any of its three detectors
	assign analog_det = i_hs_det | i_gs_det | i_vs_det;

	// ------------------------------------------------------------------
	// Interface choice; the seek state only arises without override
	// ------------------------------------------------------------------
	always_comb begin
		o_seek = 1'b0;
		if (i_if_ovr) begin
			o_if_act = i_if_sel;
		end else if (analog_det && i_link_det) begin
			o_if_act = i_if_sel;
		end else if (i_link_det) begin
			o_if_act = 1'b1;
		end else if (analog_det) begin
			o_if_act = 1'b0;
		end else begin
			o_if_act = 1'b0;
			o_seek   = 1'b1;
		end
	end

	// Hsync: without override a lone source wins, otherwise the select bit decides
	always_comb begin
		if (!i_hs_ovr && (i_hs_det != i_gs_det)) begin
			o_hs_act = i_gs_det;
		end else begin
			o_hs_act = i_hs_sel;
		end
	end

	// Without override, vsync input preferred; separator only when green sync is seen without vsync
	always_comb begin
		if (i_vs_ovr) begin
			o_vs_act = i_vs_sel;
		end else begin
			o_vs_act = !i_vs_det && i_gs_det;
		end
	end

endmodule : source_select

// *** rtl/sync_detect_interface_select.sv ***
// Output mode, sync detection and source select registers on AXI4-Lite
`timescale 1ns/1ps

module sync_detect_interface_select #(
	parameter int unsigned ACT_WINDOW_CYC = sync_detect_pkg::ACT_WINDOW_CYC,
	parameter int unsigned ADDR_W         = 8
) (
	input  wire logic              i_clk_sys,    // System clock, 100 MHz
	input  wire logic              i_rst_n,      // Sync reset, active low
	input  wire logic [ADDR_W-1:0] i_awaddr,     // Write address
	input  wire logic              i_awvalid,    // Write address valid
	output logic                   o_awready,    // Write address ready
	input  wire logic [31:0]       i_wdata,      // Write data
	input  wire logic [3:0]        i_wstrb,      // Write byte strobes
	input  wire logic              i_wvalid,     // Write data valid
	output logic                   o_wready,     // Write data ready
	output logic [1:0]             o_bresp,      // Write response
	output logic                   o_bvalid,     // Write response valid
	input  wire logic              i_bready,     // Write response ready
	input  wire logic [ADDR_W-1:0] i_araddr,     // Read address
	input  wire logic              i_arvalid,    // Read address valid
	output logic                   o_arready,    // Read address ready
	output logic [31:0]            o_rdata,      // Read data
	output logic [1:0]             o_rresp,      // Read response
	output logic                   o_rvalid,     // Read data valid
	input  wire logic              i_rready,     // Read data ready
	input  wire logic              i_hsync,      // Hsync input
	input  wire logic              i_green_channel_sync_input, // Green sync
	input  wire logic              i_vsync,      // Vsync input
	input  wire logic              i_link_clk,   // Link clock, sampled
	output logic [1:0]             o_drive_strength, // drive_t code
	output logic                   o_output_drive_en, // Data/clock pin OE
	output logic                   o_sync_detect,     // Sync detect pin
	output logic                   o_sync_detect_oe,  // Sync detect pin OE
	output logic                   o_selected_interface_status, // 1 digital
	output logic                   o_selected_hsync_status,     // 1 green
	output logic                   o_selected_vsync_status,     // 1 sep.
	output logic                   o_soft_powerdown_seek        // Seeking
);

	// ------------------------------------------------------------------
	// Types and state
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {SEL_MODE, SEL_STATUS, SEL_OVR, SEL_NONE}
		reg_sel_t;

	typedef struct packed {
		logic [7:0]               mode;
		logic [7:0]               ovr;
		logic [7:0]               status;
		logic                     seek;
		sync_detect_pkg::drive_t  drive;
		logic                     out_en;
		logic                     sd_pin;
		logic                     aw_got;
		logic [ADDR_W-1:0]        aw_addr;
		logic                     w_got;
		logic [7:0]               wdata;
		logic                     wlane0;
		logic                     bvalid;
		logic [1:0]               bresp;
		logic                     rvalid;
		logic [7:0]               rdata;
		logic [1:0]               rresp;
	} state_t;

	localparam state_t STATE_RST = '{
		mode:    sync_detect_pkg::OUTPUT_MODE_RST,
		ovr:     sync_detect_pkg::OVERRIDE_RST,
		drive:   sync_detect_pkg::DRIVE_HIGH,
		out_en:  1'b1,
		seek:    1'b1, // Inputs idle, no override: seeking from the start
		default: '0
	};

	state_t state_reg;
	state_t state_next;

	logic hs_det;
	logic gs_det;
	logic vs_det;
	logic link_det;
	logic sel_if;
	logic sel_hs;
	logic sel_vs;
	logic sel_seek;

	// Word address match; the two low byte bits are ignored
	function automatic reg_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
		logic [ADDR_W-1:0] word;
		word = addr & ~ADDR_W'(3);
		if (word == ADDR_W'(sync_detect_pkg::ADDR_OUTPUT_MODE)) begin
			return SEL_MODE;
		end
		if (word == ADDR_W'(sync_detect_pkg::ADDR_SYNC_STATUS)) begin
			return SEL_STATUS;
		end
		if (word == ADDR_W'(sync_detect_pkg::ADDR_SRC_OVERRIDE)) begin
			return SEL_OVR;
		end
		return SEL_NONE;
	endfunction : reg_sel

	// ------------------------------------------------------------------
	// Activity detectors, one per watched input
	// ------------------------------------------------------------------
	activity_detector #(.WINDOW_CYC(ACT_WINDOW_CYC)) u_det_hs (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_signal  (i_hsync),
		.o_active  (hs_det)
	);

	activity_detector #(.WINDOW_CYC(ACT_WINDOW_CYC)) u_det_gs (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_signal  (i_green_channel_sync_input),
		.o_active  (gs_det)
	);

	activity_detector #(.WINDOW_CYC(ACT_WINDOW_CYC)) u_det_vs (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_signal  (i_vsync),
		.o_active  (vs_det)
	);

	// Link clock is only sampled; above half the system rate it aliases,
	// which is why this indication is not to be trusted on its own
	activity_detector #(.WINDOW_CYC(ACT_WINDOW_CYC)) u_det_link (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (i_rst_n),
		.i_signal  (i_link_clk),
		.o_active  (link_det)
	);

	// ------------------------------------------------------------------
	// Source selection from live detections and stored overrides
	// ------------------------------------------------------------------
	source_select u_select (
		.i_hs_det   (hs_det),
		.i_gs_det   (gs_det),
		.i_vs_det   (vs_det),
		.i_link_det (link_det),
		.i_if_ovr   (state_reg.ovr[sync_detect_pkg::OV_IF_OVR]),
		.i_if_sel   (state_reg.ovr[sync_detect_pkg::OV_IF_SEL]),
		.i_hs_ovr   (state_reg.ovr[sync_detect_pkg::OV_HS_OVR]),
		.i_hs_sel   (state_reg.ovr[sync_detect_pkg::OV_HS_SEL]),
		.i_vs_ovr   (state_reg.ovr[sync_detect_pkg::OV_VS_OVR]),
		.i_vs_sel   (state_reg.ovr[sync_detect_pkg::OV_VS_SEL]),
		.o_if_act   (sel_if),
		.o_hs_act   (sel_hs),
		.o_vs_act   (sel_vs),
		.o_seek     (sel_seek)
	);

	// ------------------------------------------------------------------
	// Bus handshakes: one write and one read in flight at most
	// ------------------------------------------------------------------
	assign o_awready = !state_reg.aw_got && !state_reg.bvalid;
	assign o_wready  = !state_reg.w_got && !state_reg.bvalid;
	assign o_arready = !state_reg.rvalid;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		state_next = state_reg;

		// Status tracks the detectors every cycle, never the bus
		state_next.status = {hs_det, gs_det, vs_det, link_det,
			sel_if, sel_hs, sel_vs, 1'b0};
		state_next.seek   = sel_seek;

		// Address and data are taken independently, in either order
		if (i_awvalid && o_awready) begin
			state_next.aw_got  = 1'b1;
			state_next.aw_addr = i_awaddr;
		end
		if (i_wvalid && o_wready) begin
			state_next.w_got  = 1'b1;
			state_next.wdata  = i_wdata[7:0];
			state_next.wlane0 = i_wstrb[0];
		end

		// Response retires first so a new one can never be lost
		if (state_reg.bvalid && i_bready) begin
			state_next.bvalid = 1'b0;
		end

		// Commit once both halves are held; lane 0 carries the byte
		if (state_reg.aw_got && state_reg.w_got) begin
			state_next.aw_got = 1'b0;
			state_next.w_got  = 1'b0;
			state_next.bvalid = 1'b1;
			state_next.bresp  = sync_detect_pkg::RESP_OKAY;
			case (reg_sel(state_reg.aw_addr))
				SEL_MODE: begin
					if (state_reg.wlane0) begin
						state_next.mode = state_reg.wdata &
							sync_detect_pkg::OUTPUT_MODE_MASK;
					end
				end
				SEL_OVR: begin
					if (state_reg.wlane0) begin
						state_next.ovr = state_reg.wdata &
							sync_detect_pkg::OVERRIDE_MASK;
					end
				end
				SEL_STATUS: begin
					state_next.bresp = sync_detect_pkg::RESP_OKAY;
				end
				default: begin
					state_next.bresp = sync_detect_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Read channel
		if (state_reg.rvalid && i_rready) begin
			state_next.rvalid = 1'b0;
		end
		if (i_arvalid && o_arready) begin
			state_next.rvalid = 1'b1;
			state_next.rresp  = sync_detect_pkg::RESP_OKAY;
			case (reg_sel(i_araddr))
				SEL_MODE:   state_next.rdata = state_reg.mode;
				SEL_STATUS: state_next.rdata = state_reg.status;
				SEL_OVR:    state_next.rdata = state_reg.ovr;
				default: begin
					state_next.rdata = 8'h00;
					state_next.rresp = sync_detect_pkg::RESP_SLVERR;
				end
			endcase
		end

		// Pin controls follow the registers in the same cycle they land
		state_next.drive  = sync_detect_pkg::drive_code(
			state_next.mode[sync_detect_pkg::OM_DRIVE_LSB +: 2]);
		// Green sync and reference outputs live outside this block and
		// are never floated by this enable
		state_next.out_en =
			!state_next.mode[sync_detect_pkg::OM_TRISTATE];
		state_next.sd_pin = (|state_next.status[7:4]) ^
			state_next.mode[sync_detect_pkg::OM_SD_POL];
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			state_reg <= STATE_RST;
		end else begin
			state_reg <= state_next;
		end
	end

	// ------------------------------------------------------------------
	// Outputs, all from flip-flops apart from the ready signals
	// ------------------------------------------------------------------
	assign o_bvalid          = state_reg.bvalid;
	assign o_bresp           = state_reg.bresp;
	assign o_rvalid          = state_reg.rvalid;
	assign o_rresp           = state_reg.rresp;
	assign o_rdata           = {24'h000000, state_reg.rdata};
	assign o_drive_strength  = state_reg.drive;
	assign o_output_drive_en = state_reg.out_en;
	assign o_sync_detect     = state_reg.sd_pin;
	assign o_sync_detect_oe  = state_reg.out_en;
	assign o_selected_interface_status =
		state_reg.status[sync_detect_pkg::ST_IF_ACT];
	assign o_selected_hsync_status =
		state_reg.status[sync_detect_pkg::ST_HS_ACT];
	assign o_selected_vsync_status =
		state_reg.status[sync_detect_pkg::ST_VS_ACT];
	assign o_soft_powerdown_seek   = state_reg.seek;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb_sys @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	logic [1:0] mode_drive;
	logic       mode_tri;
	logic       mode_pol;
	logic       any_det;
	assign mode_drive = state_reg.mode[sync_detect_pkg::OM_DRIVE_LSB +: 2];
	assign mode_tri   = state_reg.mode[sync_detect_pkg::OM_TRISTATE];
	assign mode_pol   = state_reg.mode[sync_detect_pkg::OM_SD_POL];
	assign any_det    = |state_reg.status[7:4];

	property p_drive_high;
		mode_drive[1] |-> o_drive_strength == sync_detect_pkg::DRIVE_HIGH;
	endproperty
	a_drive_high: assert property (p_drive_high)
		else $error("drive strength not high with upper bit set");

	property p_tristate;
		$changed(mode_tri) |-> o_output_drive_en == !mode_tri &&
			o_sync_detect_oe == !mode_tri;
	endproperty
	a_tristate: assert property (p_tristate)
		else $error("output enable does not follow tristate bit");

	property p_sd_polarity;
		$changed(mode_pol) && $stable(any_det) |-> $changed(o_sync_detect);
	endproperty
	a_sd_polarity: assert property (p_sd_polarity)
		else $error("sync detect pin ignores polarity change");

	property p_hs_act;
		$changed(i_hsync) && $past(i_rst_n) |-> ##[1:2] state_reg.status[7];
	endproperty
	a_hs_act: assert property (p_hs_act)
		else $error("hsync toggle not reported");

	property p_gs_act;
		$changed(i_green_channel_sync_input) && $past(i_rst_n)
			|-> ##[1:2] state_reg.status[6];
	endproperty
	a_gs_act: assert property (p_gs_act)
		else $error("green sync activity not reported");

	property p_vs_act;
		$changed(i_vsync) && $past(i_rst_n) |-> ##[1:2] state_reg.status[5];
	endproperty
	a_vs_act: assert property (p_vs_act)
		else $error("vsync toggle not reported");

	property p_link_act;
		$changed(i_link_clk) && $past(i_rst_n)
			|-> ##[1:2] state_reg.status[4];
	endproperty
	a_link_act: assert property (p_link_act)
		else $error("link clock activity not reported");

	property p_seek;
		!state_reg.ovr[7] && $stable(state_reg.ovr[7]) &&
			state_reg.status[7:4] == 4'h0 |-> o_soft_powerdown_seek;
	endproperty
	a_seek: assert property (p_seek)
		else $error("seek state missing with nothing detected");

	property p_if_ovr;
		state_reg.ovr[7] && $stable(state_reg.ovr) |-> ##1
			o_selected_interface_status == $past(state_reg.ovr[6]);
	endproperty
	a_if_ovr: assert property (p_if_ovr)
		else $error("interface override not applied");

	property p_hs_ovr;
		state_reg.ovr[5] && $stable(state_reg.ovr) |-> ##1
			o_selected_hsync_status == $past(state_reg.ovr[4]);
	endproperty
	a_hs_ovr: assert property (p_hs_ovr)
		else $error("hsync override not applied");

	property p_vs_ovr;
		state_reg.ovr[3] && $stable(state_reg.ovr) |-> ##1
			o_selected_vsync_status == $past(state_reg.ovr[2]);
	endproperty
	a_vs_ovr: assert property (p_vs_ovr)
		else $error("vsync override not applied");

	c_write: cover property (o_bvalid && i_bready);
	c_read: cover property (o_rvalid && i_rready);
	c_seek_exit: cover property ($fell(o_soft_powerdown_seek));
	c_digital: cover property ($rose(o_selected_interface_status));

endmodule : sync_detect_interface_select

// *** rtl/sync_detect_pkg.sv ***
// Shared constants for the sync detect and source select register bank
package sync_detect_pkg;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_FREQ_MHZ   = 100;
	// Quiet time after which an input counts as idle, in microseconds
	localparam int unsigned ACT_WINDOW_US  = 50;
	// Longest time; microseconds times MHz gives an exact cycle count, no rounding
	localparam int unsigned ACT_WINDOW_CYC = ACT_WINDOW_US * CLK_FREQ_MHZ;

	// ------------------------------------------------------------------
	// Register indices and byte addresses (index times four)
	// ------------------------------------------------------------------
	localparam logic [7:0] IDX_OUTPUT_MODE  = 8'h10;
	localparam logic [7:0] IDX_SYNC_STATUS  = 8'h11;
	localparam logic [7:0] IDX_SRC_OVERRIDE = 8'h12;
	localparam logic [7:0] ADDR_OUTPUT_MODE  = {IDX_OUTPUT_MODE[5:0], 2'h0};
	localparam logic [7:0] ADDR_SYNC_STATUS  = {IDX_SYNC_STATUS[5:0], 2'h0};
	localparam logic [7:0] ADDR_SRC_OVERRIDE = {IDX_SRC_OVERRIDE[5:0], 2'h0};

	// ------------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------------
	localparam int unsigned OM_DRIVE_LSB = 4;  // Two-bit drive field
	localparam int unsigned OM_TRISTATE  = 3;  // output_tristate_enable
	localparam int unsigned OM_SD_POL    = 2;  // Sync detect polarity
	localparam int unsigned ST_HS_DET    = 7;
	localparam int unsigned ST_SOG_DET   = 6;
	localparam int unsigned ST_VS_DET    = 5;
	localparam int unsigned ST_LINK_DET  = 4;
	localparam int unsigned ST_IF_ACT    = 3;
	localparam int unsigned ST_HS_ACT    = 2;
	localparam int unsigned ST_VS_ACT    = 1;
	localparam int unsigned OV_IF_OVR    = 7;  // interface_select_override
	localparam int unsigned OV_IF_SEL    = 6;  // interface_select_value
	localparam int unsigned OV_HS_OVR    = 5;
	localparam int unsigned OV_HS_SEL    = 4;
	localparam int unsigned OV_VS_OVR    = 3;
	localparam int unsigned OV_VS_SEL    = 2;

	// ------------------------------------------------------------------
	// Reset values, writable masks, bus responses
	// ------------------------------------------------------------------
	localparam logic [7:0] OUTPUT_MODE_RST  = 8'h30;
	localparam logic [7:0] OUTPUT_MODE_MASK = 8'h3C;
	localparam logic [7:0] OVERRIDE_RST     = 8'h00;
	localparam logic [7:0] OVERRIDE_MASK    = 8'hFC;
	localparam logic [1:0] RESP_OKAY        = 2'h0;
	localparam logic [1:0] RESP_SLVERR      = 2'h2;

	typedef enum logic [1:0] {DRIVE_LOW, DRIVE_MEDIUM, DRIVE_HIGH} drive_t;

	// Upper bit wins regardless of the lower one
	function automatic drive_t drive_code(input logic [1:0] field);
		if (field[1]) begin
			return DRIVE_HIGH;
		end
		return field[0] ? DRIVE_MEDIUM : DRIVE_LOW;
	endfunction : drive_code

endpackage : sync_detect_pkg

// *** verif/sync_source_model.sv ***
// Model of the analog sync source and the digital link transmitter
`timescale 1ns/1ps

module sync_source_model (
	input  wire logic       i_clk_sys,  // System clock
	input  wire logic [3:0] i_en,       // Hsync, green, vsync, link on
	output logic            o_hsync,    // Hsync line
	output logic            o_green,    // Green channel sync line
	output logic            o_vsync,    // Vsync line, slow toggles
	output logic            o_link_clk  // Link clock, stands still idle
);
	logic [2:0] cnt_reg;

	// A quiet line holds its level, which must read as no activity
	initial {o_hsync, o_green, o_vsync, o_link_clk, cnt_reg} = '0;

	// Fast and slow sources, so detection is seen at both rates
	always @(posedge i_clk_sys) begin
		cnt_reg <= cnt_reg + 3'h1;
		if (i_en[3]) o_hsync <= !o_hsync;
		if (i_en[2] && cnt_reg[0]) o_green <= !o_green;
		if (i_en[1] && cnt_reg == 3'h0) o_vsync <= !o_vsync;
		if (i_en[0]) o_link_clk <= !o_link_clk;
	end
endmodule : sync_source_model

// *** verif/tb_sync_detect_interface_select.sv ***
// Self-checking bench for the sync detect and source select registers
`timescale 1ns/1ps

module tb_sync_detect_interface_select;
	logic        clk, rst_n, awvalid, wvalid, arvalid, awready, wready;
	logic        bvalid, arready, rvalid, hs, gs, vs, lk;
	logic        drv_en, sd, sd_oe, if_st, hs_st, vs_st, seek;
	logic [1:0]  bresp, rresp, drive, rsp;
	logic [3:0]  src_en;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rdat;
	int          fail_count, n_tests;

	sync_detect_interface_select #(.ACT_WINDOW_CYC(20), .ADDR_W(8))
		u_sync_detect_interface_select (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
		.i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'b1),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
		.o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(1'b1), .i_hsync(hs), .i_green_channel_sync_input(gs),
		.i_vsync(vs), .i_link_clk(lk), .o_drive_strength(drive),
		.o_output_drive_en(drv_en), .o_sync_detect(sd),
		.o_sync_detect_oe(sd_oe), .o_selected_interface_status(if_st),
		.o_selected_hsync_status(hs_st), .o_selected_vsync_status(vs_st),
		.o_soft_powerdown_seek(seek));

	sync_source_model u_sync_source_model (.i_clk_sys(clk), .i_en(src_en),
		.o_hsync(hs), .o_green(gs), .o_vsync(vs), .o_link_clk(lk));

	// Free running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic summarize();
		$display("mismatches %0d, checks %0d", fail_count, n_tests);
		if (fail_count == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize

	// Ready is looked at before the edge, as the edge itself sees it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, b;
		b = 1'b0;
		{awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
		for (int n = 0; n < 40 && !b; n++) begin
			@(negedge clk);
			{ta, tw} = {awvalid & awready, wvalid & wready};
			{b, rsp} = {bvalid, bresp};
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		if (!b) chk(32'h0, 32'h1);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic t, v;
		v = 1'b0;
		{araddr, arvalid} <= {a, 1'b1};
		for (int n = 0; n < 40 && !v; n++) begin
			@(negedge clk);
			{t, v, rsp, rdat} = {arvalid & arready, rvalid, rresp, rdata};
			@(posedge clk);
			if (t) arvalid <= 1'b0;
		end
		if (!v) chk(32'h0, 32'h1);
	endtask : rd

	// Set overrides and sources, let detection settle, check status
	task automatic det(input logic [3:0] en, input logic [7:0] ov, ex);
		wr(8'h48, {24'h0, ov});
		src_en <= en;
		repeat (30) @(posedge clk);
		rd(8'h44);
		chk(rdat, {24'h0, ex});
		chk({seek, if_st, hs_st, vs_st, sd}, {!ov[7] && ex[7:4] == 4'h0, ex[3:1],
			ex[7:4] != 4'h0});
	endtask : det

	task automatic t_reset();
		rd(8'h40);
		chk(rdat, 32'h30);
		rd(8'h48);
		chk(rdat, 32'h0);
		chk({drv_en, sd_oe, drive}, 32'hE);
	endtask : t_reset

	task automatic t_mode();
		logic [1:0] code [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
		for (int k = 0; k < 4; k++) begin
			wr(8'h40, 32'(k) << 4);
			chk(drive, code[k]);
		end
		wr(8'h40, 32'hFF);
		rd(8'h40);
		chk(rdat, 32'h3C);
		chk({drv_en, sd_oe, sd, drive}, 32'h6);
		wr(8'h40, 32'h30);
		chk({drv_en, sd_oe, sd}, 32'h6);
	endtask : t_mode

	task automatic t_access();
		wr(8'h44, 32'hFF);
		chk(rsp, sync_detect_pkg::RESP_OKAY);
		rd(8'h44);
		chk(rdat, 32'h0);
		wr(8'h4C, 32'hFF);
		chk(rsp, sync_detect_pkg::RESP_SLVERR);
		rd(8'h4C);
		chk(rsp, sync_detect_pkg::RESP_SLVERR);
		chk(rdat, 32'h0);
		wr(8'h48, 32'hFF);
		rd(8'h48);
		chk(rdat, 32'hFC);
	endtask : t_access

	task automatic t_auto();
		det(4'h0, 8'h00, 8'h00);
		det(4'h8, 8'h00, 8'h80);
		det(4'h4, 8'h00, 8'h46);
		det(4'h2, 8'h00, 8'h20);
		det(4'h1, 8'h00, 8'h18);
		det(4'hD, 8'h50, 8'hDE);
		det(4'h6, 8'h00, 8'h64);
	endtask : t_auto

	task automatic t_override();
		det(4'h1, 8'h80, 8'h10);
		det(4'h8, 8'h30, 8'h84);
		det(4'h2, 8'h0C, 8'h22);
		det(4'h0, 8'hFC, 8'h0E);
	endtask : t_override

	// Main sequence after six cycles of reset
	initial begin
		{rst_n, awvalid, wvalid, arvalid, src_en, awaddr, araddr} = '0;
		{wdata, fail_count, n_tests} = '0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_mode();
		t_access();
		t_auto();
		t_override();
		summarize();
	end

	// The run needs under five hundred cycles; a hang is cut well after
	initial begin
		repeat (5000) @(posedge clk);
		fail_count++;
		summarize();
	end
endmodule : tb_sync_detect_interface_select
